// File: src/cce_pkg.sv
// Shared constants for the call and clear instruction executor
package cce_pkg;
  localparam int INSTR_W = 14;
  localparam int PC_W = 13;
  localparam int FILE_ADDR_W = 7;
  localparam int DATA_W = 8;
  localparam int IMM_W = 11;
  // Call pattern: bits 13:11 = 100
  localparam logic [2:0] CALL_OPC = 3'h4;
  localparam int CALL_OPC_LSB = 11;
  // Clear file register: bits 13:7 = 0000011
  localparam logic [6:0] CLR_FILE_OPC = 7'h03;
  localparam int CLR_FILE_LSB = 7;
  localparam logic [13:0] CLR_WORK_CODE = 14'h0103;
  localparam logic [13:0] CLR_WDOG_CODE = 14'h0064;
  // Latch bits copied into the upper program counter bits
  localparam int LATCH_HI = 4;
  localparam int LATCH_LO = 3;
  localparam int CALL_CYCLES = 2;
  localparam logic [PC_W-1:0] PC_RST = 13'h0000;
  localparam logic [DATA_W-1:0] ZERO_DATA = 8'h00;
  localparam logic [PC_W-1:0] PC_ONE = 13'h0001;
  localparam logic [FILE_ADDR_W-1:0] ADDR_RST = 7'h00;
  // Active-low status flags come up set
  localparam logic FLAG_N_RST = 1'h1;
  typedef enum logic [2:0] {CCE_NONE, CCE_CALL, CCE_CLR_FILE, CCE_CLR_WORK, CCE_CLR_WDOG} cce_op_t;
endpackage

// File: src/cce_decode.sv
// Instruction word classifier for the call and clear instructions
`timescale 1ns/1ps
module cce_decode (
  // Instruction word
  input wire logic [13:0] instr,
  // Decoded operation
  output cce_pkg::cce_op_t op
);
  always_comb begin
    op = cce_pkg::CCE_NONE;
    if (instr[cce_pkg::INSTR_W-1:cce_pkg::CALL_OPC_LSB] == cce_pkg::CALL_OPC) begin
      op = cce_pkg::CCE_CALL;
    end else if (instr == cce_pkg::CLR_WORK_CODE) begin
      op = cce_pkg::CCE_CLR_WORK;
    end else if (instr == cce_pkg::CLR_WDOG_CODE) begin
      op = cce_pkg::CCE_CLR_WDOG;
    end else if (instr[cce_pkg::INSTR_W-1:cce_pkg::CLR_FILE_LSB] == cce_pkg::CLR_FILE_OPC) begin
      op = cce_pkg::CCE_CLR_FILE;
    end
  end
endmodule // cce_decode

// File: src/cce_exec.sv
// Execution of subroutine call and the clear instructions
//
// What this block does
// - Call pushes current PC plus one
// - Call loads 11-bit immediate into PC[10:0]
// - Call copies latch bits 4:3 into PC[12:11]
// - Call decodes, takes two cycles, no flags
// - Clear-W zeroes working register, sets zero
// - Clear-watchdog zeroes watchdog counter in one cycle
// - Clear-watchdog also zeroes prescaler, same cycle
// - Clear-watchdog sets timeout and powerdown flags
`timescale 1ns/1ps
module cce_exec (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic sys_rst,
  // Instruction issue from the fetch stage, same clock
  input wire logic instr_valid,
  input wire logic [13:0] instr,
  input wire logic [12:0] pc_in,
  input wire logic [7:0] pc_high_latch,
  // Core state updates
  output logic busy,
  output logic done,
  output logic [12:0] pc_out,
  output logic pc_load,
  output logic [12:0] stack_top,
  output logic stack_push,
  output logic [7:0] working_reg,
  output logic w_write,
  output logic [6:0] file_addr,
  output logic [7:0] file_data,
  output logic file_write,
  output logic zero_flag_set,
  output logic timeout_flag_n,
  output logic powerdown_flag_n,
  output logic watchdog_clear,
  output logic prescaler_clear
);
  typedef struct packed {
    logic busy;
    logic done;
    logic [12:0] pc;
    logic pc_load;
    logic [12:0] stk_top;
    logic push;
    logic [7:0] w;
    logic w_we;
    logic [6:0] faddr;
    logic [7:0] fdata;
    logic f_we;
    logic zset;
    logic tmo_n;
    logic pwd_n;
    logic wdog_clr;
    logic pre_clr;
  } cce_state_t;

  cce_state_t st_r;
  cce_state_t st_nxt;
  cce_pkg::cce_op_t op;

  cce_decode u_dec (
    .instr(instr),
    .op(op)
  );

  // State after reset: flags come up set, as after power-on
  function automatic cce_state_t reset_state();
    cce_state_t s;
    s.busy = 1'h0;
    s.done = 1'h0;
    s.pc = cce_pkg::PC_RST;
    s.pc_load = 1'h0;
    s.stk_top = cce_pkg::PC_RST;
    s.push = 1'h0;
    s.w = cce_pkg::ZERO_DATA;
    s.w_we = 1'h0;
    s.faddr = cce_pkg::ADDR_RST;
    s.fdata = cce_pkg::ZERO_DATA;
    s.f_we = 1'h0;
    s.zset = 1'h0;
    s.tmo_n = cce_pkg::FLAG_N_RST;
    s.pwd_n = cce_pkg::FLAG_N_RST;
    s.wdog_clr = 1'h0;
    s.pre_clr = 1'h0;
    return s;
  endfunction

  // Strobes last one cycle; data fields hold until rewritten
  function automatic cce_state_t drop_strobes(input cce_state_t cur);
    cce_state_t s;
    s = cur;
    s.done = 1'h0;
    s.pc_load = 1'h0;
    s.push = 1'h0;
    s.w_we = 1'h0;
    s.f_we = 1'h0;
    s.zset = 1'h0;
    s.wdog_clr = 1'h0;
    s.pre_clr = 1'h0;
    return s;
  endfunction

  // Wraps at the top of program memory, as the counter does
  function automatic logic [12:0] return_addr(input logic [12:0] pc);
    return_addr = pc + cce_pkg::PC_ONE;
  endfunction

  // Only two latch bits reach the counter; the rest are ignored
  function automatic logic [12:0] call_target(input logic [7:0] latch, input logic [13:0] word);
    call_target = {latch[cce_pkg::LATCH_HI:cce_pkg::LATCH_LO], word[cce_pkg::IMM_W-1:0]};
  endfunction

  // Stack depth is not tracked here; the stack counts its own pushes
  function automatic cce_state_t do_call(input cce_state_t cur, input logic [12:0] pc,
    input logic [7:0] latch, input logic [13:0] word);
    cce_state_t s;
    s = cur;
    s.stk_top = return_addr(pc);
    s.push = 1'h1;
    s.pc = call_target(latch, word);
    s.pc_load = 1'h1;
    s.busy = 1'h1;
    return s;
  endfunction

  function automatic cce_state_t do_clear_work(input cce_state_t cur);
    cce_state_t s;
    s = cur;
    s.w = cce_pkg::ZERO_DATA;
    s.w_we = 1'h1;
    s.zset = 1'h1;
    s.done = 1'h1;
    return s;
  endfunction

  function automatic cce_state_t do_clear_file(input cce_state_t cur,
    input logic [13:0] word);
    cce_state_t s;
    s = cur;
    s.faddr = word[cce_pkg::FILE_ADDR_W-1:0];
    s.fdata = cce_pkg::ZERO_DATA;
    s.f_we = 1'h1;
    s.zset = 1'h1;
    s.done = 1'h1;
    return s;
  endfunction

  function automatic cce_state_t do_clear_wdog(input cce_state_t cur);
    cce_state_t s;
    s = cur;
    s.wdog_clr = 1'h1;
    s.pre_clr = 1'h1;
    s.tmo_n = 1'h1;
    s.pwd_n = 1'h1;
    s.done = 1'h1;
    return s;
  endfunction

  // A word that matches nothing drops the strobes; data fields keep their value
  always_comb begin
    st_nxt = drop_strobes(st_r);
    if (st_r.busy) begin
      st_nxt.busy = 1'h0;
      st_nxt.done = 1'h1;
    end else if (instr_valid) begin
      case (op)
        cce_pkg::CCE_CALL: begin
          st_nxt = do_call(st_nxt, pc_in, pc_high_latch, instr);
        end
        cce_pkg::CCE_CLR_WORK: begin
          st_nxt = do_clear_work(st_nxt);
        end
        cce_pkg::CCE_CLR_FILE: begin
          st_nxt = do_clear_file(st_nxt, instr);
        end
        cce_pkg::CCE_CLR_WDOG: begin
          st_nxt = do_clear_wdog(st_nxt);
        end
        default: begin
          st_nxt.done = 1'h0;
        end
      endcase
    end
  end

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      st_r <= reset_state();
    end else begin
      st_r <= st_nxt;
    end
  end

  // Every output is a register field
  assign busy = st_r.busy;
  assign done = st_r.done;
  assign pc_out = st_r.pc;
  assign pc_load = st_r.pc_load;
  assign stack_top = st_r.stk_top;
  assign stack_push = st_r.push;
  assign working_reg = st_r.w;
  assign w_write = st_r.w_we;
  assign file_addr = st_r.faddr;
  assign file_data = st_r.fdata;
  assign file_write = st_r.f_we;
  assign zero_flag_set = st_r.zset;
  assign timeout_flag_n = st_r.tmo_n;
  assign powerdown_flag_n = st_r.pwd_n;
  assign watchdog_clear = st_r.wdog_clr;
  assign prescaler_clear = st_r.pre_clr;
endmodule // cce_exec

// File: tb/cce_exec_props.sv
// Assertion checker for the call and clear executor
`timescale 1ns/1ps
module cce_exec_props (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic sys_rst,
  // Instruction issue
  input wire logic instr_valid,
  input wire logic [13:0] instr,
  input wire logic [12:0] pc_in,
  input wire logic [7:0] pc_high_latch,
  // Executor outputs
  input wire logic busy,
  input wire logic done,
  input wire logic [12:0] pc_out,
  input wire logic pc_load,
  input wire logic [12:0] stack_top,
  input wire logic stack_push,
  input wire logic [7:0] working_reg,
  input wire logic w_write,
  input wire logic [6:0] file_addr,
  input wire logic [7:0] file_data,
  input wire logic file_write,
  input wire logic zero_flag_set,
  input wire logic timeout_flag_n,
  input wire logic powerdown_flag_n,
  input wire logic watchdog_clear,
  input wire logic prescaler_clear
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (sys_rst);
  // Busy cycle of a call must not accept a new word
  wire logic tk = instr_valid && !busy;
  call_push_a: assert property (tk && instr[13:11] == 3'h4 |=> stack_push && stack_top == $past(pc_in) + 13'h0001)
    else $error("call return address wrong");
  call_target_a: assert property (tk && instr[13:11] == 3'h4 |=> pc_load && pc_out[10:0] == $past(instr[10:0]))
    else $error("call target wrong");
  call_latch_a: assert property (tk && instr[13:11] == 3'h4 |=> pc_out[12:11] == $past(pc_high_latch[4:3]))
    else $error("call upper bits wrong");
  call_cycles_a: assert property (tk && instr[13:11] == 3'h4 |=> busy && !done && !zero_flag_set ##1 done && !busy)
    else $error("call timing wrong");
  busy_single_a: assert property (busy |=> !busy && !pc_load && !stack_push)
    else $error("busy longer than one cycle");
  nomatch_quiet_a: assert property (tk && instr == 14'h3FFF |=> !done && !pc_load && !zero_flag_set)
    else $error("unknown word had an effect");
  clear_work_a: assert property (tk && instr == 14'h0103 |=> w_write && working_reg == 8'h00 && zero_flag_set && done)
    else $error("clear W wrong");
  wdog_clear_a: assert property (tk && instr == 14'h0064 |=> watchdog_clear && done)
    else $error("watchdog clear missing");
  prescale_same_a: assert property (watchdog_clear == prescaler_clear)
    else $error("prescaler clear not with counter");
  wdog_flags_a: assert property (tk && instr == 14'h0064 |=> timeout_flag_n && powerdown_flag_n)
    else $error("status flags not set");
  clear_file_a: assert property (tk && instr[13:7] == 7'h03 |=> file_write && file_addr == $past(instr[6:0]))
    else $error("clear file wrong");
  file_zero_a: assert property (file_write |-> file_data == 8'h00 && zero_flag_set)
    else $error("file write data not zero");
endmodule // cce_exec_props
bind cce_exec cce_exec_props props_u (
  .ref_clk(ref_clk),
  .sys_rst(sys_rst),
  .instr_valid(instr_valid),
  .instr(instr),
  .pc_in(pc_in),
  .pc_high_latch(pc_high_latch),
  .busy(busy),
  .done(done),
  .pc_out(pc_out),
  .pc_load(pc_load),
  .stack_top(stack_top),
  .stack_push(stack_push),
  .working_reg(working_reg),
  .w_write(w_write),
  .file_addr(file_addr),
  .file_data(file_data),
  .file_write(file_write),
  .zero_flag_set(zero_flag_set),
  .timeout_flag_n(timeout_flag_n),
  .powerdown_flag_n(powerdown_flag_n),
  .watchdog_clear(watchdog_clear),
  .prescaler_clear(prescaler_clear)
);

// File: tb/cce_exec_bench.sv
// Self-checking bench for the call and clear executor
`timescale 1ns/1ps
module cce_exec_bench;
  logic ref_clk = 1'h0, sys_rst = 1'h1, instr_valid = 1'h0;
  logic [13:0] instr = 14'h0000;
  logic [12:0] pc_in = 13'h0000, pc_out, stack_top, m_pc = 13'h0000, m_top = 13'h0000;
  logic [7:0] pc_high_latch = 8'h00, working_reg, file_data;
  logic [6:0] file_addr, m_fa = 7'h00;
  logic [4:0] m_str = 5'h00;
  logic busy, done, pc_load, stack_push, w_write, file_write, zero_flag_set;
  logic timeout_flag_n, powerdown_flag_n, watchdog_clear, prescaler_clear;
  logic [55:0] q[$];
  int err_total = 0, check_count = 0;
  always #50 ref_clk = ~ref_clk;
  cce_exec dut_u (
    .ref_clk(ref_clk), .sys_rst(sys_rst), .instr_valid(instr_valid), .instr(instr), .pc_in(pc_in),
    .pc_high_latch(pc_high_latch), .busy(busy), .done(done), .pc_out(pc_out), .pc_load(pc_load),
    .stack_top(stack_top), .stack_push(stack_push), .working_reg(working_reg), .w_write(w_write),
    .file_addr(file_addr), .file_data(file_data), .file_write(file_write), .zero_flag_set(zero_flag_set),
    .timeout_flag_n(timeout_flag_n), .powerdown_flag_n(powerdown_flag_n), .watchdog_clear(watchdog_clear),
    .prescaler_clear(prescaler_clear)
  );
  task automatic complete_run();
    if (err_total == 0 && check_count > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  task automatic issue(input logic [13:0] i, input logic [12:0] p);
    instr_valid = 1'h1;
    instr = i;
    pc_in = p;
    pc_high_latch = 8'($urandom);
    if (i[13:11] == 3'h4) begin
      m_top = p + 13'h0001;
      m_pc = {pc_high_latch[4:3], i[10:0]};
    end
    if (i[13:7] == 7'h03) m_fa = i[6:0];
    // Strobes seen with done: W write, file write, zero set, watchdog clear, prescaler clear
    m_str = i[13:7] == 7'h03 ? 5'h0C : i == 14'h0103 ? 5'h14 : i == 14'h0064 ? 5'h03 : 5'h00;
    if (i[13:11] == 3'h4 || i[13:7] == 7'h03 || i == 14'h0103 || i == 14'h0064) begin
      q.push_back({m_pc, m_top, 8'h00, m_fa, 2'h3, m_str, 8'h00});
    end
    @(posedge ref_clk);
    #1;
    if (i[13:11] == 3'h4) begin
      // Word offered in the busy cycle must be dropped
      instr = 14'h0103;
      @(posedge ref_clk);
      #1;
    end
  endtask
  always @(posedge ref_clk) begin
    if (!sys_rst && done === 1'h1) begin
      check_count++;
      if (q.size() == 0 || {pc_out, stack_top, working_reg, file_addr, timeout_flag_n, powerdown_flag_n, w_write,
        file_write, zero_flag_set, watchdog_clear, prescaler_clear, file_data} !== q.pop_front()) begin
        err_total++;
        $display("mismatch at %0t: result differs", $time);
      end
    end
  end
  initial begin
    int k;
    void'($urandom(32'hC70B));
    repeat (2) @(posedge ref_clk);
    #1 sys_rst = 1'h0;
    issue(14'h27FF, 13'h1FFF);
    issue(14'h2000, 13'h0005);
    issue(14'h0064, 13'h0000);
    issue(14'h0103, 13'h0001);
    issue(14'h01FF, 13'h0002);
    issue(14'h3FFF, 13'h0000);
    repeat (80) begin
      k = $urandom % 5;
      issue(k == 0 ? {3'h4, 11'($urandom)} : k == 1 ? {7'h03, 7'($urandom)} : k == 2 ? 14'h0103 :
        k == 3 ? 14'h0064 : 14'h3FFF, 13'($urandom));
    end
    instr_valid = 1'h0;
    repeat (4) @(posedge ref_clk);
    if (q.size() != 0) begin
      err_total++;
      $display("mismatch at %0t: results missing", $time);
    end
    complete_run();
  end
  initial begin
    #1ms;
    err_total++;
    $display("mismatch at %0t: run timed out", $time);
    complete_run();
  end
endmodule // cce_exec_bench
